//--- design/ccc_pkg.sv
package ccc_pkg;
	// ****************************************
	// charge state encoding
	// ****************************************
	typedef enum logic [3:0] {
		ST_SLEEP    = 4'h0, // no adapter supply
		ST_IDLE     = 4'h1, // disabled by charge-enable
		ST_PRECHG   = 4'h2, // precharge phase
		ST_FAST     = 4'h3, // constant-current phase
		ST_CV       = 4'h4, // constant-voltage phase
		ST_DONE     = 4'h5, // charge complete
		ST_TFAULT   = 4'h6, // timer fault
		ST_OVP      = 4'h7, // overvoltage
		ST_DISCHG   = 4'h8, // absent test: discharge
		ST_WAKE     = 4'h9, // absent test: wake
		ST_ABSENT   = 4'ha, // battery absent
		ST_SUSPEND  = 4'hb  // temperature suspend
	} ccc_state_type;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 100; // clock rate
	localparam int BLINK_HZ_X10 = 5; // 0.5 Hz blink, tenths of Hz
	// half period of blink in cycles: 1 s
	localparam int BLINK_HALF_CYC = CLK_MHZ * 1000000 * 10 / BLINK_HZ_X10 / 2;
	localparam int DISCHG_MS = 1000; // discharge test time
	localparam int WAKE_MS = 500; // wake test time
	localparam int DISCHG_CYC = DISCHG_MS * CLK_MHZ * 1000;
	localparam int WAKE_CYC = WAKE_MS * CLK_MHZ * 1000;
	localparam int PRECHG_CYC = 32'd180000000; // precharge timeout default
	localparam int CHARGE_CYC = 32'd1800000000; // fast timeout default
	localparam logic [1:0] CELL_ONE = 2'h1; // 4.2 V regulation
	localparam logic [1:0] CELL_TWO = 2'h2; // 8.4 V regulation
endpackage

//--- design/ccc_tmr_if.sv
`timescale 1ns/10ps
// ****************************************
// timer control between controller and counter
// ****************************************
interface ccc_tmr_if;
	logic clear; // restart count
	logic run; // count enabled
	logic [31:0] limit; // cycles to expire
	logic expired; // limit reached
	modport ctrl (output clear, output run, output limit, input expired);
	modport tmr (input clear, input run, input limit, output expired);
endinterface

//--- design/ccc_timer.sv
`timescale 1ns/10ps
module ccc_timer
	import ccc_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // sync reset
	ccc_tmr_if.tmr t // timer control
);
	// ****************************************
	// counter holds its value while run is low
	// ****************************************
	logic [31:0] cnt_ff; // elapsed cycles
	logic exp_ff; // expired flag

	// count and hold; clear wins
	always_ff @(posedge clk)
	begin
		if (rst || t.clear)
			cnt_ff <= 32'h0;
		else if (t.run && !exp_ff)
			cnt_ff <= cnt_ff + 32'h1;
	end

	// expiry flag
	always_ff @(posedge clk)
	begin
		if (rst || t.clear)
			exp_ff <= 1'b0;
		else if (t.run && (cnt_ff + 32'h1 >= t.limit))
			exp_ff <= 1'b1;
	end

	assign t.expired = exp_ff;
endmodule // ccc_timer

//--- design/ccc_top.sv
`timescale 1ns/10ps
// Operation
// - end charge at termination current in CV
// - safety timer backs up current termination
// - restart on recharge, POR, enable, timer pin
// - timer pin low disables termination and timer
// - timer pin high disables only the timer
// - cell select picks one or two cells
// - sleep whenever adapter supply absent
// - status pins encode charge state
// - blink variant flashes first pin on faults
// - power good on above sleep exit
// - low charge-enable enables charging
// - enable falling edge clears timers and faults
// - fault above recharge waits then absent test
// - fault below recharge applies probe current
// - probe stops above recharge, then recover
// - POR or enable toggle clears timer fault
// - overvoltage stops switching, clears at recharge
// - host version rate select forces rate
// - host version enters CV at regulation
// - host version has no timers, termination
// - host version overvoltage stops all switches
// - temperature suspend holds timer values
// - precharge timeout gives fault and probe
// - absent test discharge then wake check
module ccc_top
	import ccc_pkg::*;
#(
	parameter int PRECHG_LIMIT = PRECHG_CYC, // precharge timeout cycles
	parameter int CHARGE_LIMIT = CHARGE_CYC, // fast timeout cycles
	parameter int DISCHG_LIMIT = DISCHG_CYC, // discharge test cycles
	parameter int WAKE_LIMIT = WAKE_CYC, // wake test cycles
	parameter int BLINK_HALF = BLINK_HALF_CYC, // blink half period
	parameter bit HOST_CTRL = 1'b0, // host-controlled version
	parameter bit BLINK_VARIANT = 1'b0 // blinking status variant
)
(
	input wire logic clk, // system clock
	input wire logic rst, // sync reset, power-on
	input wire logic supply_ok_pin, // adapter above sleep exit
	input wire logic charge_en_n_pin, // charge enable, low active
	input wire logic cells_pin, // cell count select
	input wire logic rate_select_pin, // host rate select
	input wire logic timer_pin_low, // timer pin below enable
	input wire logic timer_pin_high, // timer pin tied high
	input wire logic below_recharge_pin, // battery below recharge
	input wire logic below_prechg_pin, // battery below precharge
	input wire logic at_regulation_pin, // battery at regulation
	input wire logic at_term_current_pin, // current at termination
	input wire logic overvoltage_pin, // battery overvoltage
	input wire logic temp_bad_pin, // temperature out of range
	input wire logic short_pin, // battery below short level
	output logic switching_en, // PWM stage enable
	output logic cv_mode, // voltage regulation phase
	output logic fast_rate, // fast rate, else precharge
	output logic [1:0] cell_mode, // regulation target
	output logic probe_current, // removal probe current
	output logic discharge_current, // absent test sink
	output logic wake_current, // absent test wake
	output logic sleep_mode, // low power sleep
	output logic status_out_a, // status a open-drain out
	output logic status_out_a_oe, // status a pull enable
	output logic status_out_b, // status b open-drain out
	output logic status_out_b_oe, // status b pull enable
	output logic power_good_n, // power good open-drain out
	output logic power_good_n_oe // power good pull enable
);
	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int NIN = 13; // synchronised pins
	logic [NIN-1:0] raw_in; // pin bundle
	logic [NIN-1:0] sy1_ff; // first stage
	logic [NIN-1:0] sy2_ff; // second stage

	assign raw_in = {supply_ok_pin, charge_en_n_pin, cells_pin,
		rate_select_pin, timer_pin_low, timer_pin_high,
		below_recharge_pin, below_prechg_pin, at_regulation_pin,
		at_term_current_pin, overvoltage_pin, temp_bad_pin, short_pin};

	// two flops per pin, one loop
	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					sy1_ff[gi] <= 1'b0;
					sy2_ff[gi] <= 1'b0;
				end
				else
				begin
					sy1_ff[gi] <= raw_in[gi];
					sy2_ff[gi] <= sy1_ff[gi];
				end
			end
		end
	endgenerate

	logic supply_ok, ce_n, cells, rate_sel, tp_low, tp_high; // synced
	logic below_rch, below_pre, at_reg, at_term, ovp, temp_bad; // synced
	logic short_bat; // synced
	assign {supply_ok, ce_n, cells, rate_sel, tp_low, tp_high, below_rch,
		below_pre, at_reg, at_term, ovp, temp_bad, short_bat} = sy2_ff;

	// ****************************************
	// edge detection and captured history
	// ****************************************
	logic ce_n_d_ff; // previous enable level
	logic tp_low_d_ff; // previous timer pin low level
	logic first_ff; // first cycle after reset done
	logic ce_fall; // enable asserted
	logic ce_rise; // enable removed
	logic tp_rise; // timer pin re-enabled

	// first_ff masks the edge detectors until the history is real
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ce_n_d_ff <= 1'b1;
			tp_low_d_ff <= 1'b0;
			first_ff <= 1'b0;
		end
		else
		begin
			ce_n_d_ff <= ce_n;
			tp_low_d_ff <= tp_low;
			first_ff <= 1'b1;
		end
	end

	assign ce_fall = first_ff && ce_n_d_ff && !ce_n;
	assign ce_rise = first_ff && !ce_n_d_ff && ce_n;
	assign tp_rise = first_ff && tp_low_d_ff && !tp_low;

	// ****************************************
	// timers
	// ****************************************
	ccc_tmr_if safety_if(); // precharge and fast timer
	ccc_tmr_if test_if(); // absent test timer

	ccc_timer u_safety (
		.clk(clk),
		.rst(rst),
		.t(safety_if.tmr)
	);

	ccc_timer u_test (
		.clk(clk),
		.rst(rst),
		.t(test_if.tmr)
	);

	ccc_state_type st_ff; // charge state
	ccc_state_type nxt_st; // next state
	logic timer_on; // safety timer allowed
	logic term_on; // termination allowed
	logic restart; // start a new cycle

	// timer pin low kills both; tied high kills only the timer
	assign timer_on = !HOST_CTRL && !tp_low && !tp_high;
	assign term_on = !HOST_CTRL && !tp_low;
	assign restart = ce_fall || tp_rise;

	// safety timer cleared on entry to precharge or fast, enable edge, pin re-enable
	// leaving a suspend is no phase change: the count carries on
	assign safety_if.clear = restart || (st_ff != nxt_st &&
		st_ff != ST_SUSPEND &&
		(nxt_st == ST_PRECHG || nxt_st == ST_FAST));
	// suspend leaves run low so the count holds
	assign safety_if.run = timer_on &&
		(st_ff == ST_PRECHG || st_ff == ST_FAST || st_ff == ST_CV);
	assign safety_if.limit = (st_ff == ST_PRECHG) ? 32'(PRECHG_LIMIT) :
		32'(CHARGE_LIMIT);

	assign test_if.clear = (st_ff != nxt_st); // restart on every move
	assign test_if.run = (st_ff == ST_DISCHG || st_ff == ST_WAKE);
	assign test_if.limit = (st_ff == ST_DISCHG) ? 32'(DISCHG_LIMIT) :
		32'(WAKE_LIMIT);

	// ****************************************
	// charge state machine
	// ****************************************
	ccc_state_type resume_ff; // phase to resume after suspend

	// next state, priorities: sleep, disable, overvoltage, suspend
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			ST_SLEEP:
				nxt_st = ST_IDLE;
			ST_IDLE:
				if (!ce_n)
					nxt_st = below_pre ? ST_PRECHG : ST_FAST;
			ST_PRECHG:
				if (safety_if.expired)
					nxt_st = ST_TFAULT;
				else if (!below_pre || HOST_CTRL)
					nxt_st = ST_FAST;
			ST_FAST:
				if (safety_if.expired)
					nxt_st = ST_TFAULT;
				else if (at_reg)
					nxt_st = ST_CV;
			ST_CV:
				if (safety_if.expired)
					nxt_st = ST_TFAULT;
				else if (term_on && at_term)
					nxt_st = ST_DONE;
			ST_DONE:
				if (below_rch)
					nxt_st = ST_DISCHG;
			ST_TFAULT:
				// wait above recharge, then fall below it
				if (below_rch && !probe_current)
					nxt_st = ST_DISCHG;
			ST_OVP:
				if (below_rch)
					nxt_st = HOST_CTRL ? ST_IDLE : ST_DISCHG;
			ST_DISCHG:
				// only an empty terminal collapses under the sink
				if (test_if.expired)
					nxt_st = short_bat ? ST_WAKE : ST_PRECHG;
			ST_WAKE:
				if (test_if.expired)
					nxt_st = below_rch ? ST_PRECHG : ST_ABSENT;
			ST_ABSENT:
				if (below_rch)
					nxt_st = ST_DISCHG;
			ST_SUSPEND:
				if (!temp_bad)
					nxt_st = resume_ff;
			default:
				nxt_st = ST_IDLE;
		endcase
		// overrides
		if ((st_ff == ST_PRECHG || st_ff == ST_FAST || st_ff == ST_CV) &&
			temp_bad && !HOST_CTRL)
			nxt_st = ST_SUSPEND;
		if (ovp)
			nxt_st = ST_OVP;
		if (restart && !ce_n && !ovp)
			nxt_st = below_pre ? ST_PRECHG : ST_FAST;
		if (ce_n)
			nxt_st = ST_IDLE;
		if (!supply_ok)
			nxt_st = ST_SLEEP;
	end

	// state register; reset counts as power-on
	always_ff @(posedge clk)
	begin
		if (rst)
			st_ff <= ST_SLEEP;
		else
			st_ff <= nxt_st;
	end

	// remember the phase interrupted by a suspend
	always_ff @(posedge clk)
	begin
		if (rst)
			resume_ff <= ST_FAST;
		else if (nxt_st == ST_SUSPEND && st_ff != ST_SUSPEND)
			resume_ff <= st_ff;
	end

	// ****************************************
	// blink divider
	// ****************************************
	logic [31:0] blink_cnt_ff; // half period counter
	logic blink_ff; // square wave
	logic blink_state; // a blinking state holds
	logic blink_state_d_ff; // previous blinking state

	assign blink_state = BLINK_VARIANT && (nxt_st == ST_TFAULT ||
		nxt_st == ST_SUSPEND || (nxt_st == ST_PRECHG && short_bat));

	// restart on entry so the first on period is full length
	always_ff @(posedge clk)
	begin
		if (rst || (blink_state && !blink_state_d_ff))
		begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= 1'b1;
		end
		else if (blink_cnt_ff >= 32'(BLINK_HALF - 1))
		begin
			blink_cnt_ff <= 32'h0;
			blink_ff <= !blink_ff;
		end
		else
			blink_cnt_ff <= blink_cnt_ff + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			blink_state_d_ff <= 1'b0;
		else
			blink_state_d_ff <= blink_state;
	end

	// ****************************************
	// outputs, all registered
	// ****************************************
	logic on_a; // status a request
	logic on_b; // status b request

	// status table; overvoltage, absent and sleep give both off
	always_comb
	begin
		on_a = (nxt_st == ST_PRECHG || nxt_st == ST_FAST ||
			nxt_st == ST_CV);
		on_b = (nxt_st == ST_DONE);
		if (blink_state)
			on_a = blink_ff || !blink_state_d_ff;
	end

	// pins drive zero; the enable pulls low when on
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			status_out_a_oe <= 1'b0;
			status_out_b_oe <= 1'b0;
			power_good_n_oe <= 1'b0;
		end
		else
		begin
			status_out_a_oe <= on_a;
			status_out_b_oe <= on_b;
			power_good_n_oe <= supply_ok && nxt_st != ST_SLEEP;
		end
	end

	// open-drain data lines are a constant low
	always_ff @(posedge clk)
	begin
		status_out_a <= 1'b0;
		status_out_b <= 1'b0;
		power_good_n <= 1'b0;
	end

	// power stage controls
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			switching_en <= 1'b0;
			cv_mode <= 1'b0;
			fast_rate <= 1'b0;
			probe_current <= 1'b0;
			discharge_current <= 1'b0;
			wake_current <= 1'b0;
			sleep_mode <= 1'b1;
			cell_mode <= CELL_ONE;
		end
		else
		begin
			switching_en <= (nxt_st == ST_PRECHG || nxt_st == ST_FAST ||
				nxt_st == ST_CV);
			cv_mode <= (nxt_st == ST_CV);
			fast_rate <= HOST_CTRL ? rate_sel :
				(nxt_st != ST_PRECHG);
			// probe on in fault while below recharge
			probe_current <= (nxt_st == ST_TFAULT) &&
				(st_ff != ST_TFAULT ? below_rch :
				(probe_current && below_rch));
			discharge_current <= (nxt_st == ST_DISCHG);
			wake_current <= (nxt_st == ST_WAKE);
			sleep_mode <= (nxt_st == ST_SLEEP);
			cell_mode <= cells ? CELL_TWO : CELL_ONE;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sleep_off_a: assert property (@(posedge clk) disable iff (rst)
		sleep_mode |-> !power_good_n_oe && !status_out_a_oe &&
		!status_out_b_oe) else $error("outputs on in sleep");
	pg_follow_a: assert property (@(posedge clk) disable iff (rst)
		$rose(sy2_ff[12]) |-> ##[1:3] power_good_n_oe)
		else $error("power good late");
	term_done_a: assert property (@(posedge clk) disable iff (rst)
		st_ff == ST_CV && term_on && at_term && !safety_if.expired &&
		!ovp && !ce_n && supply_ok && !temp_bad && !restart
		|=> st_ff == ST_DONE) else $error("no termination");
	ovp_stop_a: assert property (@(posedge clk) disable iff (rst)
		ovp && supply_ok && !ce_n |=> !switching_en && !status_out_a_oe)
		else $error("switching in overvoltage");
	ce_off_a: assert property (@(posedge clk) disable iff (rst)
		ce_n |-> ##1 !switching_en) else $error("charge while off");
	done_b_a: assert property (@(posedge clk) disable iff (rst)
		st_ff == ST_DONE |=> status_out_b_oe || st_ff != ST_DONE)
		else $error("complete not shown");
	susp_hold_a: assert property (@(posedge clk) disable iff (rst)
		st_ff == ST_SUSPEND && !restart |=> !switching_en ||
		st_ff != ST_SUSPEND) else $error("switching in suspend");
	host_nt_a: assert property (@(posedge clk) disable iff (rst)
		HOST_CTRL |-> st_ff != ST_TFAULT && st_ff != ST_DONE)
		else $error("host version terminated");
	cell_sel_a: assert property (@(posedge clk) disable iff (rst)
		cells |=> cell_mode == CELL_TWO) else $error("cell mode");
	probe_a: assert property (@(posedge clk) disable iff (rst)
		probe_current |-> st_ff == ST_TFAULT && $past(below_rch))
		else $error("probe outside fault");
endmodule // ccc_top

//--- test/ccc_pack_model.sv
`timescale 1ns/10ps
// ****************************************
// battery pack comparators and pin pull-ups
// ****************************************
module ccc_pack_model
#(
	parameter int TERM_DELAY = 12, // taper cycles before term level
	parameter int PRECHG_MV = 3000, // precharge threshold
	parameter int SHORT_MV = 2000, // short threshold
	parameter int RCH_MV = 100, // recharge delta below regulation
	parameter int OVP_MV = 200 // overvoltage margin over regulation
)
(
	input wire logic clk, // system clock
	input wire logic [15:0] bat_mv, // pack voltage in mV
	input wire logic [1:0] cell_mode, // regulation target
	input wire logic switching_en, // charger switching
	input wire logic cv_mode, // voltage phase
	input wire logic status_out_a_oe, // pin a pulled low
	input wire logic status_out_b_oe, // pin b pulled low
	input wire logic power_good_n_oe, // power good pulled low
	output logic below_recharge, // under recharge level
	output logic below_prechg, // under precharge level
	output logic at_regulation, // at regulation level
	output logic at_term_current, // taper reached term level
	output logic overvoltage, // above overvoltage level
	output logic short_level, // under short level
	output logic pin_a, // resolved status a
	output logic pin_b, // resolved status b
	output logic pin_pg // resolved power good
);
	int reg_mv; // regulation level, one or two cells
	int taper_cnt = 0; // cycles spent in voltage phase

	// ****************************************
	// comparator levels
	// ****************************************
	assign reg_mv = 4200 * int'(cell_mode);
	assign below_recharge = int'(bat_mv) < reg_mv - RCH_MV;
	assign below_prechg = int'(bat_mv) < PRECHG_MV;
	assign at_regulation = int'(bat_mv) >= reg_mv;
	assign overvoltage = int'(bat_mv) > reg_mv + OVP_MV;
	assign short_level = int'(bat_mv) < SHORT_MV;
	assign at_term_current = taper_cnt >= TERM_DELAY;

	// current tapers slowly, so termination answers late on purpose
	always @(posedge clk)
	begin
		if (switching_en === 1'b1 && cv_mode === 1'b1)
			taper_cnt <= taper_cnt + 1;
		else
			taper_cnt <= 0;
	end

	// ****************************************
	// open-drain pins with pull-ups
	// ****************************************
	assign pin_a = status_out_a_oe ? 1'b0 : 1'b1;
	assign pin_b = status_out_b_oe ? 1'b0 : 1'b1;
	assign pin_pg = power_good_n_oe ? 1'b0 : 1'b1;
endmodule // ccc_pack_model

//--- test/charge_cycle_controller_bench.sv
`timescale 1ns/10ps
module charge_cycle_controller_bench;
	import ccc_pkg::*;
	// ****************************************
	// settings and signals
	// ****************************************
	localparam int PRE_LIM = 40; // short precharge timeout
	localparam int CHG_LIM = 80; // short fast timeout
	localparam int TEST_LIM = 20; // absent test phases
	localparam int MAX_CYC = 3000; // hang ceiling
	// inputs {supply, ce_n, cells, tlow, thigh, temp}
	// expect {switching, pin a, pin b, pin pg, cell_mode}
	typedef struct {logic [5:0] in; int mv; int cyc; logic [5:0] exp;}
		ccc_row_type;
	logic clk = 1'b0; // system clock
	logic rst = 1'b1; // sync reset
	logic sup = 1'b1, ce_n = 1'b1, cells = 1'b0, rate = 1'b1; // pins
	logic tlow = 1'b0, thigh = 1'b1, temp = 1'b0; // pins
	logic [15:0] bat_mv = 16'h0e10; // pack voltage, 3600 mV
	logic brch, bpre, areg, aterm, ovp, shrt; // comparators
	logic sw, cv, fast, probe, dis, wake, slp; // dut levels
	logic [1:0] rate_select; // regulation target
	logic sa, sa_oe, sb, sb_oe, pg, pg_oe; // open-drain pins
	logic pin_a, pin_b, pin_pg; // resolved pins
	int num_errors = 0; // mismatches
	int checks = 0; // comparisons
	int cyc_cnt = 0; // hang counter
	ccc_row_type rows [12] = '{
		'{6'b110010, 3600, 8, 6'b011001}, // idle, enable high
		'{6'b100010, 3600, 8, 6'b101001}, // charging
		'{6'b100010, 4200, 40, 6'b010001}, // regulation, then done
		'{6'b100010, 4050, 70, 6'b101001}, // recharge restart
		'{6'b100011, 4050, 8, 6'b011001}, // temperature suspend
		'{6'b100010, 4050, 8, 6'b101001}, // resume
		'{6'b100010, 4500, 8, 6'b011001}, // overvoltage
		'{6'b100010, 4000, 70, 6'b101001}, // overvoltage cleared
		'{6'b101010, 4000, 8, 6'b101010}, // two cells
		'{6'b100010, 4000, 8, 6'b101001}, // one cell
		'{6'b000010, 4000, 8, 6'b011101}, // sleep
		'{6'b100010, 4000, 12, 6'b101001}}; // supply back

	always #5 clk = ~clk;

	ccc_top #(.PRECHG_LIMIT(PRE_LIM), .CHARGE_LIMIT(CHG_LIM),
		.DISCHG_LIMIT(TEST_LIM), .WAKE_LIMIT(TEST_LIM), .BLINK_HALF(30))
	i_dut (.clk(clk), .rst(rst), .supply_ok_pin(sup),
		.charge_en_n_pin(ce_n), .cells_pin(cells), .rate_select_pin(rate),
		.timer_pin_low(tlow), .timer_pin_high(thigh),
		.below_recharge_pin(brch), .below_prechg_pin(bpre),
		.at_regulation_pin(areg), .at_term_current_pin(aterm),
		.overvoltage_pin(ovp), .temp_bad_pin(temp), .short_pin(shrt),
		.switching_en(sw), .cv_mode(cv), .fast_rate(fast),
		.cell_mode(rate_select), .probe_current(probe),
		.discharge_current(dis), .wake_current(wake), .sleep_mode(slp),
		.status_out_a(sa), .status_out_a_oe(sa_oe), .status_out_b(sb),
		.status_out_b_oe(sb_oe), .power_good_n(pg),
		.power_good_n_oe(pg_oe));

	ccc_pack_model i_pack (.clk(clk), .bat_mv(bat_mv), .cell_mode(rate_select),
		.switching_en(sw), .cv_mode(cv), .status_out_a_oe(sa_oe),
		.status_out_b_oe(sb_oe), .power_good_n_oe(pg_oe),
		.below_recharge(brch), .below_prechg(bpre), .at_regulation(areg),
		.at_term_current(aterm), .overvoltage(ovp), .short_level(shrt),
		.pin_a(pin_a), .pin_b(pin_b), .pin_pg(pin_pg));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
		input string what);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t %s seen %h want %h", $time, what, seen, exp);
		end
	endtask

	// inputs change at the edge, outputs looked at just after one
	task automatic step(input logic [5:0] in, input int mv, input int cyc);
		@(posedge clk);
		{sup, ce_n, cells, tlow, thigh, temp} <= in;
		bat_mv <= 16'(mv);
		repeat (cyc) @(posedge clk);
		#1;
	endtask

	task automatic give_verdict;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// a hang counts as a mismatch and closes the run
	always @(posedge clk)
	begin
		cyc_cnt++;
		if (cyc_cnt == MAX_CYC)
		begin
			num_errors++;
			give_verdict();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		check({2'h0, sa_oe, sb_oe, pg_oe, slp, rate_select}, 8'h05, "reset");
		@(posedge clk);
		rst <= 1'b0;
		// timer pin tied high keeps the safety timer out of the table
		foreach (rows[i])
		begin
			step(rows[i].in, rows[i].mv, rows[i].cyc);
			check({2'h0, sw, pin_a, pin_b, pin_pg, rate_select}, {2'h0, rows[i].exp},
				"row");
		end
		// safety timer runs out with the battery under recharge
		step(6'b110000, 3600, 6);
		step(6'b100000, 3600, CHG_LIM + 10);
		check({sw, pin_a, pin_b, probe}, 8'h07, "fault");
		step(6'b100000, 4150, 6);
		check({7'h0, probe}, 8'h00, "probe off");
		step(6'b100000, 4050, 6);
		check({7'h0, dis}, 8'h01, "absent test");
		step(6'b100000, 4050, 2 * TEST_LIM + 20);
		check({7'h0, sw}, 8'h01, "test failed");
		// precharge never reaches its threshold
		step(6'b110000, 2500, 6);
		step(6'b100000, 2500, PRE_LIM + 10);
		check({sw, probe}, 8'h01, "precharge fault");
		step(6'b110000, 2500, 6);
		step(6'b100000, 2500, 6);
		check({sw, fast, probe}, 8'h04, "enable clear");
		// timer pin low: no timer, no termination
		step(6'b100100, 3600, CHG_LIM + 20);
		check({sw, pin_a}, 8'h02, "timer off");
		step(6'b100100, 4200, 40);
		check({sw, cv, pin_b}, 8'h07, "no term");
		step(6'b100000, 4200, 40);
		check({sw, pin_b}, 8'h00, "re-enabled");
		// timer pin high: timer off, termination kept
		step(6'b110010, 3600, 6);
		step(6'b100010, 3600, CHG_LIM + 20);
		check({7'h0, sw}, 8'h01, "timer high");
		step(6'b100010, 4200, 40);
		check({sw, pin_b}, 8'h00, "term kept");
		// pack pulled out: the sink finds a short, the wake finds full level
		step(6'b100010, 1500, 30);
		check({dis, wake}, 8'h01, "wake test");
		step(6'b100010, 4200, 40);
		check({sw, pin_a, pin_b, wake, sa, sb, pg}, 8'h30,
			"absent");
		give_verdict();
	end
endmodule // charge_cycle_controller_bench
